// [hdl/dac_load_pkg.sv]
// constants for the dual converter serial load logic
package dac_load_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned CODE_BITS    = 12;
  localparam int unsigned MODE_POS     = 15;
  localparam int unsigned SEL_B_POS    = 14;
  localparam int unsigned SEL_A_POS    = 13;
  localparam int unsigned CHANNELS     = 2;
  localparam int unsigned CH_FIRST     = 0;
  localparam int unsigned CH_SECOND    = 1;

  // ----------------------------------------------------------------
  // reset and preset values
  // ----------------------------------------------------------------
  localparam logic [CODE_BITS-1:0]  HALF_SCALE  = 12'h800;
  localparam logic [CODE_BITS-1:0]  ZERO_SCALE  = 12'h000;
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
  localparam logic                  IDLE_HIGH   = 1'h1;

endpackage

// [hdl/code_register.sv]
// one converter register with asynchronous preset override
`timescale 1ns/100ps
`default_nettype none
module code_register
  import dac_load_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 asyncPreset_n,
  input  wire logic                 presetLevelSelect,
  input  wire logic                 load,
  input  wire logic [CODE_BITS-1:0] codeIn,
  output logic      [CODE_BITS-1:0] code
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [CODE_BITS-1:0] code_q;
  logic [CODE_BITS-1:0] presetValue;

  assign presetValue = presetLevelSelect ? HALF_SCALE : ZERO_SCALE;

  // preset also written into storage so it persists after release
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      code_q <= ZERO_SCALE;
    end else if (!asyncPreset_n) begin
      code_q <= presetValue;
    end else if (load) begin
      code_q <= codeIn;
    end
  end

  // combinational override: preset acts with no clock edge
  assign code = !asyncPreset_n ? presetValue : code_q;

endmodule
`default_nettype wire

// [hdl/dual_dac_serial_load.sv]
// serial front end and load decode of a dual 12-bit converter
`timescale 1ns/100ps
`default_nettype none
module dual_dac_serial_load
  import dac_load_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 serialIn,
  input  wire logic                 shiftClk,
  input  wire logic                 chipSelect_n,
  input  wire logic                 loadStrobeA_n,
  input  wire logic                 loadStrobeB_n,
  input  wire logic                 asyncPreset_n,
  input  wire logic                 presetLevelSelect,
  output logic                      serialOut,
  output logic      [CODE_BITS-1:0] converterRegisterFirst,
  output logic      [CODE_BITS-1:0] converterRegisterSecond
);

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  // pins are synchronous to clk, so a single past sample suffices
  logic shiftClkPrev_q;
  logic strobeAPrev_q;
  logic strobeBPrev_q;
  logic shiftRise;
  logic strobeAFall;
  logic strobeBFall;
  logic shiftEnable;

  // shift history idles high so a clock high at release is no rise;
  // strobe history follows the pin so a strobe held low is no fall
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shiftClkPrev_q <= IDLE_HIGH;
      strobeAPrev_q  <= loadStrobeA_n;
      strobeBPrev_q  <= loadStrobeB_n;
    end else begin
      shiftClkPrev_q <= shiftClk;
      strobeAPrev_q  <= loadStrobeA_n;
      strobeBPrev_q  <= loadStrobeB_n;
    end
  end

  assign shiftRise   = shiftClk & ~shiftClkPrev_q;
  assign shiftEnable = shiftRise & ~chipSelect_n;
  // strobes decoded without chip select
  assign strobeAFall = strobeAPrev_q & ~loadStrobeA_n;
  assign strobeBFall = strobeBPrev_q & ~loadStrobeB_n;

  // ----------------------------------------------------------------
  // shift register
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] shift_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shift_q <= SHIFT_RESET;
    end else if (shiftEnable) begin
      shift_q <= {shift_q[FRAME_BITS-2:0], serialIn};
    end
  end

  // last stage feeds the chain; never tri-stated
  assign serialOut = shift_q[FRAME_BITS-1];

  // ----------------------------------------------------------------
  // load decode
  // ----------------------------------------------------------------
  logic                 modeSoft;
  logic                 selA;
  logic                 selB;
  logic                 anyFall;
  logic [CHANNELS-1:0]  loadCh;
  logic [CODE_BITS-1:0] frameCode;
  logic [CODE_BITS-1:0] codeOut [CHANNELS];

  assign modeSoft  = shift_q[MODE_POS];
  assign selA      = shift_q[SEL_A_POS];
  assign selB      = shift_q[SEL_B_POS];
  // software mode treats the two strobes as one control
  assign anyFall   = strobeAFall | strobeBFall;
  assign frameCode = shift_q[CODE_BITS-1:0];

  always_comb begin
    if (modeSoft) begin
      loadCh[CH_FIRST]  = anyFall & selA;
      loadCh[CH_SECOND] = anyFall & selB;
    end else begin
      loadCh[CH_FIRST]  = strobeAFall;
      loadCh[CH_SECOND] = strobeBFall;
    end
  end

  // ----------------------------------------------------------------
  // converter registers
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : gChannel
      code_register uReg (
        .clk               (clk),
        .reset_n           (reset_n),
        .asyncPreset_n     (asyncPreset_n),
        .presetLevelSelect (presetLevelSelect),
        .load              (loadCh[ch]),
        .codeIn            (frameCode),
        .code              (codeOut[ch])
      );
    end
  endgenerate

  assign converterRegisterFirst  = codeOut[CH_FIRST];
  assign converterRegisterSecond = codeOut[CH_SECOND];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic presetQuiet;
  assign presetQuiet = asyncPreset_n;

  property p_shift_in;
    (shiftClk && !shiftClkPrev_q && !chipSelect_n) |=>
      shift_q == {$past(shift_q[FRAME_BITS-2:0]), $past(serialIn)};
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("shift register did not take serial input");

  property p_hold_deselected;
    chipSelect_n |=> $stable(shift_q);
  endproperty
  a_hold_deselected: assert property (p_hold_deselected)
    else $error("shift register moved while deselected");

  property p_chain_out;
    (shiftClk && !shiftClkPrev_q && !chipSelect_n) |=>
      serialOut == $past(shift_q[FRAME_BITS-2]);
  endproperty
  a_chain_out: assert property (p_chain_out)
    else $error("serial output not the next stage bit");

  property p_out_steady;
    chipSelect_n ##1 chipSelect_n |-> $stable(serialOut);
  endproperty
  a_out_steady: assert property (p_out_steady)
    else $error("serial output changed without a shift");

  property p_hw_load_a;
    (!modeSoft && strobeAPrev_q && !loadStrobeA_n && presetQuiet) ##1
      presetQuiet |-> converterRegisterFirst == $past(frameCode);
  endproperty
  a_hw_load_a: assert property (p_hw_load_a)
    else $error("hardware load of first register missed");

  property p_hw_no_load;
    (!modeSoft && !strobeAFall && !strobeBFall && presetQuiet) ##1
      presetQuiet |-> $stable(converterRegisterFirst)
        && $stable(converterRegisterSecond);
  endproperty
  a_hw_no_load: assert property (p_hw_no_load)
    else $error("register changed without a strobe");

  property p_sw_load_a;
    (modeSoft && selA && !selB && anyFall && presetQuiet) ##1
      presetQuiet |-> converterRegisterFirst == $past(frameCode)
        && $stable(converterRegisterSecond);
  endproperty
  a_sw_load_a: assert property (p_sw_load_a)
    else $error("software decode load of first register wrong");

  property p_sw_load_b;
    (modeSoft && selB && !selA && anyFall && presetQuiet) ##1
      presetQuiet |-> converterRegisterSecond == $past(frameCode)
        && $stable(converterRegisterFirst);
  endproperty
  a_sw_load_b: assert property (p_sw_load_b)
    else $error("software decode load of second register wrong");

  property p_sw_load_both;
    (modeSoft && selA && selB && anyFall && presetQuiet) ##1
      presetQuiet |-> converterRegisterFirst == $past(frameCode)
        && converterRegisterSecond == $past(frameCode);
  endproperty
  a_sw_load_both: assert property (p_sw_load_both)
    else $error("software decode load of both registers wrong");

  property p_sw_none;
    (modeSoft && !selA && !selB && presetQuiet) ##1 presetQuiet |->
      $stable(converterRegisterFirst) && $stable(converterRegisterSecond);
  endproperty
  a_sw_none: assert property (p_sw_none)
    else $error("software decode loaded with no select");

  property p_preset;
    !asyncPreset_n |->
      converterRegisterFirst == (presetLevelSelect ? HALF_SCALE : ZERO_SCALE)
      && converterRegisterSecond == converterRegisterFirst;
  endproperty
  a_preset: assert property (p_preset)
    else $error("preset value not forced");

  property p_code_only;
    (!modeSoft && strobeBFall && presetQuiet) ##1 presetQuiet |->
      converterRegisterSecond == $past(shift_q[CODE_BITS-1:0]);
  endproperty
  a_code_only: assert property (p_code_only)
    else $error("second register got more than the code bits");

endmodule
`default_nettype wire

// [test/host_model.sv]
// host side model driving the serial load pins
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic clk,
  input  wire logic serialOut,
  output logic      serialIn,
  output logic      shiftClk,
  output logic      chipSelect_n,
  output logic      loadStrobeA_n,
  output logic      loadStrobeB_n
);
  // ----------
  // frame and strobe tasks
  // ----------
  initial begin
    serialIn = 1'h0;
    shiftClk = 1'h0;
    chipSelect_n = 1'h1;
    loadStrobeA_n = 1'h1;
    loadStrobeB_n = 1'h1;
  end
  // strobes stay high while shifting
  task automatic sendFrame(input logic [15:0] f, input logic cs,
                           output logic [15:0] seen);
    chipSelect_n <= cs;
    for (int i = 15; i >= 0; i--) begin // msb first
      @(posedge clk);
      serialIn <= f[i];
      shiftClk <= 1'h0;
      @(posedge clk);
      seen[i] = serialOut;
      shiftClk <= 1'h1;
    end
    @(posedge clk);
    shiftClk <= 1'h0;
    serialIn <= ~f[0]; // stale data never looks valid
    chipSelect_n <= 1'h1;
  endtask
  // tied strobes or one held high in software mode
  task automatic pulse(input logic a, input logic b, input logic csn);
    @(posedge clk);
    chipSelect_n  <= csn; // strobes act at either select level
    loadStrobeA_n <= ~a;
    loadStrobeB_n <= ~b;
    repeat (2) @(posedge clk);
    loadStrobeA_n <= 1'h1;
    loadStrobeB_n <= 1'h1;
    chipSelect_n  <= 1'h1;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [test/dual_dac_serial_load_test.sv]
// self-checking bench for the dual converter load logic
`timescale 1ns/100ps
`default_nettype none
module dual_dac_serial_load_test;
  import dac_load_pkg::*;
  logic                 clk, reset_n, serialIn, shiftClk, chipSelect_n;
  logic                 loadStrobeA_n, loadStrobeB_n, serialOut;
  logic                 asyncPreset_n, presetLevelSelect;
  logic [CODE_BITS-1:0] regA, regB, expA, expB, code;
  logic [15:0]          seen;
  int                   failures, n_compared;
  // ----------
  // harness
  // ----------
  dual_dac_serial_load DUT (
    .clk                     (clk),
    .reset_n                 (reset_n),
    .serialIn                (serialIn),
    .shiftClk                (shiftClk),
    .chipSelect_n            (chipSelect_n),
    .loadStrobeA_n           (loadStrobeA_n),
    .loadStrobeB_n           (loadStrobeB_n),
    .asyncPreset_n           (asyncPreset_n),
    .presetLevelSelect       (presetLevelSelect),
    .serialOut               (serialOut),
    .converterRegisterFirst  (regA),
    .converterRegisterSecond (regB)
  );
  host_model host (
    .clk           (clk),
    .serialOut     (serialOut),
    .serialIn      (serialIn),
    .shiftClk      (shiftClk),
    .chipSelect_n  (chipSelect_n),
    .loadStrobeA_n (loadStrobeA_n),
    .loadStrobeB_n (loadStrobeB_n)
  );
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] s,
                     input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic regs(input logic [11:0] a, input logic [11:0] b);
    chk("first", {4'h0, regA}, {4'h0, a});
    chk("second", {4'h0, regB}, {4'h0, b});
  endtask
  task automatic end_of_test;
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // bounded run, a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end
  // ----------
  // scenarios
  // ----------
  initial begin
    reset_n = 1'h0;
    asyncPreset_n = 1'h1;
    presetLevelSelect = 1'h0;
    failures = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    chk("serialOut", {15'h0, serialOut}, 16'h0000);
    regs(12'h000, 12'h000);
    // hardware mode, selects and unused bit set as noise
    host.sendFrame(16'h7abc, 1'h0, seen);
    host.pulse(1'h1, 1'h0, 1'h1);
    regs(12'habc, 12'h000);
    host.sendFrame(16'h0123, 1'h0, seen);
    chk("serialOut", seen, 16'h7abc);
    host.pulse(1'h0, 1'h1, 1'h1);
    regs(12'habc, 12'h123);
    host.sendFrame(16'h0456, 1'h0, seen);
    host.pulse(1'h1, 1'h1, 1'h1);
    regs(12'h456, 12'h456);
    expA = 12'h456;
    expB = 12'h456;
    // software decode, every select pair, strobes mixed
    for (int s = 0; s < 4; s++) begin
      code = 12'h5a0 | 12'(s);
      host.sendFrame({1'h1, 2'(s), 1'h0, code}, 1'h0, seen);
      host.pulse(s != 2, s != 1, s[0]);
      if (s[0]) expA = code;
      if (s[1]) expB = code;
      regs(expA, expB);
    end
    // shifting with chip select high is ignored, strobes then load the held frame
    host.sendFrame(16'h0321, 1'h0, seen);
    host.sendFrame(16'hffff, 1'h1, seen);
    chk("serialOut", seen, 16'h0000);
    host.pulse(1'h1, 1'h1, 1'h0);
    regs(12'h321, 12'h321);
    // preset acts without a clock edge
    @(posedge clk);
    presetLevelSelect <= 1'h1;
    asyncPreset_n <= 1'h0;
    #5;
    regs(HALF_SCALE, HALF_SCALE);
    @(posedge clk);
    presetLevelSelect <= 1'h0;
    #5;
    regs(12'h000, 12'h000);
    @(posedge clk);
    asyncPreset_n <= 1'h1;
    host.pulse(1'h1, 1'h0, 1'h1);
    regs(12'h321, 12'h000);
    end_of_test();
  end
endmodule
`default_nettype wire
